// ### tb.sv
// self-checking bench for the watchdog and fetch trap block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic I_CLK = 0, I_RST_B = 0, i_ce = 1, i_ctrl1_wr = 0, i_ctrl2_wr = 0, i_wdog_ovf = 0, i_fetch = 0;
  logic i_low_speed_mode_one = 0, i_irq_master_flag = 0, i_nmi_return_instr = 0, i_nmi_ack, prv = 0;
  logic [7:0] i_wdata = 8'h00, o_ctrl1_rdata;
  logic [15:0] i_fetch_addr = 16'h0000, i_ram_lo, i_ram_hi, i_sfa_lo, i_sfa_hi;
  logic o_fetch_trap_irq, o_wdog_overflow_irq, o_nmi_req, o_int_reset, o_hf_osc_restart, o_ovf_sel, o_trap_sel;
  logic o_ram_trap_active, m_ovf = 1, m_ts = 1, m_ra = 1, m_rp = 1;
  logic [3:0] o_nest_depth, q[$];
  logic [1:0] dly = 2'h0;
  int failures = 0, n_tests = 0, nirq = 0, rlen = 0, k;
  always #2 I_CLK = ~I_CLK;
  wdt_trap dut (.*);
  wdt_core_model core (.clk(I_CLK), .req(o_nmi_req), .dly(dly), .ack(i_nmi_ack));
  task automatic chk(input string nm, input logic [7:0] e, g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic op(input logic w1, w2, ov, f, input logic [7:0] d, input logic [15:0] a);
    logic bad, r;
    bad = f && (a >= i_sfa_lo && a <= i_sfa_hi || m_ra && a >= i_ram_lo && a <= i_ram_hi);
    r = bad && m_ts || ov && m_ovf;
    nirq += int'(bad && !m_ts || ov && !m_ovf);
    if (bad || ov) q.push_back({r && i_low_speed_mode_one, r, ov && !m_ovf, bad && !m_ts});
    {i_ctrl1_wr, i_ctrl2_wr, i_wdog_ovf, i_fetch, i_wdata, i_fetch_addr} = {w1, w2, ov, f, d, a};
    @(negedge I_CLK);
    {i_ctrl1_wr, i_ctrl2_wr, i_wdog_ovf, i_fetch} = 4'h0;
    if (w1) {m_ovf, m_ts, m_rp} = {m_ovf & d[0], d[4], d[5]};
    if (w2 && d == 8'hD2) m_ra = m_rp;
    if (w1 || w2) chk("bits", {5'h00, m_ovf, m_ts, m_ra}, {5'h00, o_ovf_sel, o_trap_sel, o_ram_trap_active});
    repeat (r ? 26 : 1) @(negedge I_CLK);
  endtask
  // results are matched to notes in issue order
  always @(negedge I_CLK) begin
    logic [3:0] ev;
    ev = {o_hf_osc_restart && o_int_reset && !prv, o_int_reset && !prv, o_wdog_overflow_irq, o_fetch_trap_irq};
    if (!o_int_reset && prv) chk("reset_len", 8'd24, 8'(rlen));
    rlen = o_int_reset ? rlen + 1 : 0;
    prv = o_int_reset;
    if (ev != 4'h0) chk("event", {4'h0, q.size() > 0 ? q.pop_front() : 4'hF}, {4'h0, ev});
  end
  initial begin
    #200000;
    failures++;
    complete_run;
  end
  initial begin
    void'($urandom(34));
    dly = 2'($urandom);
    i_sfa_lo = 16'h0000;
    i_sfa_hi = 16'h0010 + 16'($urandom % 48);
    i_ram_lo = i_sfa_hi + 16'h0001;
    i_ram_hi = i_ram_lo + 16'h01FF;
    repeat (16) @(negedge I_CLK);
    I_RST_B = 1;
    @(negedge I_CLK);
    chk("reset_bits", 8'h07, {5'h00, o_ovf_sel, o_trap_sel, o_ram_trap_active});
    chk("rdata", 8'h00, o_ctrl1_rdata);
    i_low_speed_mode_one = 1;
    op(0, 0, 1, 0, 8'h00, 16'h0000);
    i_low_speed_mode_one = 0;
    op(0, 0, 0, 1, 8'h00, i_sfa_hi);
    op(1, 0, 0, 0, 8'h01, 16'h0000);
    op(0, 0, 0, 1, 8'h00, i_ram_hi);
    op(0, 1, 0, 0, 8'h4E, 16'h0000);
    op(0, 1, 0, 0, 8'hD2, 16'h0000);
    op(0, 0, 0, 1, 8'h00, i_ram_lo);
    op(0, 0, 0, 1, 8'h00, i_sfa_lo);
    op(1, 0, 0, 0, 8'h00, 16'h0000);
    op(1, 0, 0, 0, 8'h01, 16'h0000);
    op(0, 0, 1, 0, 8'h00, 16'h0000);
    // random mix, one idle cycle apart, 26 after a reset, master flag toggling has no effect
    repeat (300) begin
      k = $urandom % 8;
      i_irq_master_flag = 1'($urandom);
      i_low_speed_mode_one = 1'($urandom);
      op(k == 0, k == 1, k == 2 || k == 7, k > 2, (k == 1 && $urandom % 2) ? 8'hD2 : 8'($urandom),
        i_sfa_lo + 16'($urandom % 700));
    end
    repeat (8) @(negedge I_CLK);
    chk("pending", 8'h00, 8'(q.size()));
    chk("depth", nirq > 15 ? 8'd15 : 8'(nirq), {4'h0, o_nest_depth});
    k = nirq > 15 ? 14 : (nirq > 0 ? nirq - 1 : 0);
    i_nmi_return_instr = 1;
    @(negedge I_CLK);
    i_nmi_return_instr = 0;
    @(negedge I_CLK);
    chk("depth_ret", 8'(k), {4'h0, o_nest_depth});
    complete_run;
  end
endmodule
`default_nettype wire

// ### wdt_core_model.sv
// core side model that takes each non-maskable request after a set delay
`timescale 1ns/1ps
`default_nettype none
module wdt_core_model (
  input  wire logic       clk,
  input  wire logic       req,
  input  wire logic [1:0] dly,
  output logic            ack
);
  logic [3:0] pipe_q = 4'h0;
  // taken even mid service and whatever the master flag
  // its stack is taken as set up before the first request
  always @(negedge clk) begin
    pipe_q <= {pipe_q[2:0], req};
  end
  assign ack = pipe_q[dly];
endmodule
`default_nettype wire

// ### wdt_rst_pulse.sv
// internal reset pulse stretcher timed on the high frequency clock
`timescale 1ns/1ps
`default_nettype none
module wdt_rst_pulse #(
  parameter int unsigned CYCLES = wdt_trap_pkg::RST_CYCLES
) (
  input  wire logic I_CLK,
  input  wire logic I_RST_B,
  input  wire logic i_ce,
  input  wire logic i_trig,
  output logic      o_active
);
  typedef enum logic [1:0] {IDLE = 2'b00, HOLD = 2'b01} st_t;
  st_t st_q, st_d;
  logic [wdt_trap_pkg::RST_CNT_W-1:0] cnt_q, cnt_d;

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      IDLE: begin
        if (i_trig) begin
          st_d  = HOLD;
          cnt_d = wdt_trap_pkg::RST_CNT_W'(CYCLES - 1);
        end
      end
      HOLD: begin
        // never longer than the limit, counted in fast clocks
        if (cnt_q == '0) begin
          st_d = IDLE;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: st_d = IDLE;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      st_q  <= IDLE;
      cnt_q <= '0;
    end else if (i_ce) begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  assign o_active = (st_q == HOLD);
endmodule
`default_nettype wire

// ### wdt_trap.sv
// watchdog overflow action and instruction fetch address trap
`timescale 1ns/1ps
`default_nettype none
// How it works
// - overflow with overflow select 1 raises a watchdog reset request
// - watchdog reset request drives internal hardware reset
// - internal reset lasts at most 24 fast clock periods
// - reset from low speed mode one restarts fast oscillator, timed in fast clocks
// - trap bits share addresses of watchdog control registers one and two
// - RAM trap enable takes effect only after D2H written to register two
// - fetch from special function area always traps
// - trap select 0: illegal fetch raises trap interrupt
// - trap select 1: illegal fetch raises trap reset request
// - trap reset request drives internal hardware reset
// - trap interrupt is non-maskable, ignores master flag
// - new trap interrupt taken at once, earlier one held pending
// - overflow select 0: overflow raises watchdog interrupt
// - once overflow select cleared, software cannot set it again
// - register one is write only, reads are don't care
module wdt_trap #(
  parameter int unsigned RST_CYCLES = wdt_trap_pkg::RST_CYCLES
) (
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST_B,
  input  wire logic        i_ce,
  // register writes from the core
  input  wire logic        i_ctrl1_wr,
  input  wire logic        i_ctrl2_wr,
  input  wire logic [7:0]  i_wdata,
  // watchdog counter and power mode
  input  wire logic        i_wdog_ovf,
  input  wire logic        i_low_speed_mode_one,
  // fetch path
  input  wire logic        i_fetch,
  input  wire logic [15:0] i_fetch_addr,
  // range configuration
  input  wire logic [15:0] i_ram_lo,
  input  wire logic [15:0] i_ram_hi,
  input  wire logic [15:0] i_sfa_lo,
  input  wire logic [15:0] i_sfa_hi,
  // interrupt service handshake
  input  wire logic        i_irq_master_flag,
  input  wire logic        i_nmi_ack,
  input  wire logic        i_nmi_return_instr,
  // results
  output logic             o_fetch_trap_irq,
  output logic             o_wdog_overflow_irq,
  output logic             o_nmi_req,
  output logic [3:0]       o_nest_depth,
  output logic             o_int_reset,
  output logic             o_hf_osc_restart,
  output logic             o_ovf_sel,
  output logic             o_trap_sel,
  output logic             o_ram_trap_active,
  output logic [7:0]       o_ctrl1_rdata
);
  // address windows checked per fetch
  localparam int unsigned N_RANGES = 2;
  localparam int unsigned RNG_RAM  = 0;
  localparam int unsigned RNG_SFA  = 1;

  // control bits of the shared register one location
  logic                      ovf_sel_q;
  logic                      ovf_sel_d;
  logic                      trap_sel_q;
  logic                      trap_sel_d;
  logic                      ram_trap_pend_q;
  logic                      ram_trap_pend_d;
  logic                      ram_trap_q;
  logic                      ram_trap_d;
  // interrupt pulses
  logic                      trap_irq_q;
  logic                      trap_irq_d;
  logic                      wdog_irq_q;
  logic                      wdog_irq_d;
  // nesting count
  logic [3:0]                nest_q;
  logic [3:0]                nest_d;
  // oscillator restart
  logic                      osc_q;
  logic                      osc_d;
  // decode and compare
  logic [N_RANGES-1:0][15:0] rng_lo;
  logic [N_RANGES-1:0][15:0] rng_hi;
  logic [N_RANGES-1:0]       in_rng;
  logic                      in_ram;
  logic                      in_sfa;
  logic                      illegal;
  logic                      ctrl2_load;
  logic                      nest_up;
  logic                      nest_down;
  logic                      rst_trig;
  logic                      rst_active;

  assign rng_lo = {i_sfa_lo, i_ram_lo};
  assign rng_hi = {i_sfa_hi, i_ram_hi};

  // one comparator per window, on the fetch cycle itself
  for (genvar g = 0; g < N_RANGES; g++) begin : g_rng
    assign in_rng[g] = (i_fetch_addr >= rng_lo[g]) && (i_fetch_addr <= rng_hi[g]);
  end

  assign in_ram  = in_rng[RNG_RAM];
  assign in_sfa  = in_rng[RNG_SFA];
  // special area always traps, RAM only when armed
  assign illegal = i_fetch && (in_sfa || (in_ram && ram_trap_q));
  // reset requests from overflow or trap
  assign rst_trig = (i_wdog_ovf && ovf_sel_q) || (illegal && trap_sel_q);
  // load code in register two
  assign ctrl2_load = i_ctrl2_wr && (i_wdata == wdt_trap_pkg::CTRL2_TRAP_LOAD);
  // saturating both ways, too deep a nest is a software fault
  assign nest_up    = i_nmi_ack && !i_nmi_return_instr && (nest_q != 4'hF);
  assign nest_down  = i_nmi_return_instr && !i_nmi_ack && (nest_q != 4'h0);

  // control bit group
  always_comb begin
    ovf_sel_d       = ovf_sel_q;
    trap_sel_d      = trap_sel_q;
    ram_trap_pend_d = ram_trap_pend_q;
    ram_trap_d      = ram_trap_q;
    // bits in shared register one location
    if (i_ctrl1_wr) begin
      // overflow select is sticky once cleared
      ovf_sel_d       = ovf_sel_q & i_wdata[wdt_trap_pkg::CTRL1_OVF_SEL_BIT];
      trap_sel_d      = i_wdata[wdt_trap_pkg::CTRL1_TRAP_SEL_BIT];
      ram_trap_pend_d = i_wdata[wdt_trap_pkg::CTRL1_RAM_TRAP_BIT];
    end
    // load code makes the staged bit live
    if (ctrl2_load) begin
      ram_trap_d = i_ctrl1_wr ? i_wdata[wdt_trap_pkg::CTRL1_RAM_TRAP_BIT] : ram_trap_pend_q;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ovf_sel_q       <= wdt_trap_pkg::CTRL1_RESET[wdt_trap_pkg::CTRL1_OVF_SEL_BIT];
      trap_sel_q      <= wdt_trap_pkg::CTRL1_RESET[wdt_trap_pkg::CTRL1_TRAP_SEL_BIT];
      ram_trap_pend_q <= wdt_trap_pkg::CTRL1_RESET[wdt_trap_pkg::CTRL1_RAM_TRAP_BIT];
      ram_trap_q      <= wdt_trap_pkg::CTRL1_RESET[wdt_trap_pkg::CTRL1_RAM_TRAP_BIT];
    end else if (i_ce) begin
      ovf_sel_q       <= ovf_sel_d;
      trap_sel_q      <= trap_sel_d;
      ram_trap_pend_q <= ram_trap_pend_d;
      ram_trap_q      <= ram_trap_d;
    end
  end

  // interrupt group, independent of master flag
  always_comb begin
    trap_irq_d = illegal && !trap_sel_q;
    wdog_irq_d = i_wdog_ovf && !ovf_sel_q;
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      trap_irq_q <= 1'b0;
      wdog_irq_q <= 1'b0;
    end else if (i_ce) begin
      trap_irq_q <= trap_irq_d;
      wdog_irq_q <= wdog_irq_d;
    end
  end

  // nesting group
  always_comb begin
    nest_d = nest_q;
    // each accepted nmi nests over the one in service, up to depth 15
    if (nest_up) begin
      nest_d = nest_q + 4'h1;
    end else if (nest_down) begin
      nest_d = nest_q - 4'h1;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      nest_q <= 4'h0;
    end else if (i_ce) begin
      nest_q <= nest_d;
    end
  end

  // oscillator group
  always_comb begin
    osc_d = osc_q;
    // only a trigger the stretcher accepts sets the mode flag
    if (rst_trig && !rst_active) begin
      osc_d = i_low_speed_mode_one;
    end else if (!rst_active) begin
      // pulse end not visible here, so this falls one cycle late
      osc_d = 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      osc_q <= 1'b0;
    end else if (i_ce) begin
      osc_q <= osc_d;
    end
  end

  // one stretcher serves both reset sources
  wdt_rst_pulse #(
    .CYCLES (RST_CYCLES)
  ) u_pulse (
    .I_CLK    (I_CLK),
    .I_RST_B  (I_RST_B),
    .i_ce     (i_ce),
    .i_trig   (rst_trig),
    .o_active (rst_active)
  );

  assign o_fetch_trap_irq    = trap_irq_q;
  assign o_wdog_overflow_irq = wdog_irq_q;
  // unmasked: master flag deliberately not consulted
  assign o_nmi_req           = trap_irq_q | wdog_irq_q;
  assign o_nest_depth        = nest_q;
  assign o_int_reset         = rst_active;
  assign o_hf_osc_restart    = osc_q;
  assign o_ovf_sel           = ovf_sel_q;
  assign o_trap_sel          = trap_sel_q;
  assign o_ram_trap_active   = ram_trap_q;
  // write only location, reads give nothing useful
  assign o_ctrl1_rdata       = 8'h00;

  // master flag is an input only to document that it is ignored
  logic unused_imf;
  assign unused_imf = i_irq_master_flag;
endmodule
`default_nettype wire

// ### wdt_trap_pkg.sv
// shared constants for the watchdog reset and fetch trap block
package wdt_trap_pkg;
  // control register one field positions
  localparam int unsigned CTRL1_OVF_SEL_BIT  = 0;
  localparam int unsigned CTRL1_TRAP_SEL_BIT = 4;
  localparam int unsigned CTRL1_RAM_TRAP_BIT = 5;
  // control register one reset value
  localparam logic [7:0] CTRL1_RESET        = 8'h39;
  // control register two codes
  localparam logic [7:0] CTRL2_TRAP_LOAD    = 8'hD2;
  // reset pulse timing
  localparam int unsigned RST_TIME_FC        = 24;
  localparam int unsigned RST_CYCLES         = RST_TIME_FC;
  localparam int unsigned RST_CNT_W          = 5;
  // default address ranges
  localparam logic [15:0] RAM_LO_RESET       = 16'h0040;
  localparam logic [15:0] RAM_HI_RESET       = 16'h023F;
  localparam logic [15:0] SFA_LO_RESET       = 16'h0000;
  localparam logic [15:0] SFA_HI_RESET       = 16'h003F;
endpackage

// ### wdt_trap_props.sv
// port checks for the watchdog and fetch trap block
`timescale 1ns/1ps
`default_nettype none
module wdt_trap_props #(
  parameter int unsigned RST_CYCLES = wdt_trap_pkg::RST_CYCLES
) (
  input wire logic        I_CLK, I_RST_B, i_ce, i_ctrl2_wr, i_wdog_ovf, i_low_speed_mode_one, i_fetch,
  input wire logic [7:0]  i_wdata,
  input wire logic [15:0] i_fetch_addr, i_ram_lo, i_ram_hi, i_sfa_lo, i_sfa_hi,
  input wire logic        i_nmi_ack, i_nmi_return_instr, o_fetch_trap_irq, o_wdog_overflow_irq, o_int_reset,
  input wire logic        o_hf_osc_restart, o_ovf_sel, o_trap_sel, o_ram_trap_active,
  input wire logic [3:0]  o_nest_depth
);
  logic [4:0] len_q;
  logic       bad;
  assign bad = i_fetch && (i_fetch_addr >= i_sfa_lo && i_fetch_addr <= i_sfa_hi
    || o_ram_trap_active && i_fetch_addr >= i_ram_lo && i_fetch_addr <= i_ram_hi);
  // frozen with the clock enable, as the block is
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) len_q <= 5'h00;
    else if (i_ce) len_q <= o_int_reset ? len_q + 5'h01 : 5'h00;
  end
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  trap_irq_a: assert property (i_ce && bad && !o_trap_sel |=> o_fetch_trap_irq) else $error("trap irq");
  trap_rst_a: assert property (i_ce && bad && o_trap_sel && !o_int_reset |=> o_int_reset) else $error("trap rst");
  wdog_rst_a: assert property (i_ce && i_wdog_ovf && o_ovf_sel && !o_int_reset |=> o_int_reset) else $error("wd rst");
  wdog_irq_a: assert property (i_ce && i_wdog_ovf && !o_ovf_sel |=> o_wdog_overflow_irq) else $error("wd irq");
  rst_len_a: assert property ($fell(o_int_reset) |-> len_q == 5'(RST_CYCLES)) else $error("rst len");
  osc_restart_a: assert property ($rose(o_int_reset) |-> o_hf_osc_restart == $past(i_low_speed_mode_one))
    else $error("osc restart");
  ovf_lock_a: assert property (!o_ovf_sel |=> !o_ovf_sel) else $error("ovf relock");
  ram_load_a: assert property ($changed(o_ram_trap_active) |-> $past(i_ctrl2_wr && i_wdata == wdt_trap_pkg::CTRL2_TRAP_LOAD))
    else $error("ram load");
  nest_up_a: assert property (i_ce && i_nmi_ack && !i_nmi_return_instr && o_nest_depth != 4'hF
    |=> o_nest_depth == $past(o_nest_depth) + 4'h1) else $error("nest");
endmodule
bind wdt_trap wdt_trap_props #(.RST_CYCLES(RST_CYCLES)) u_props (.*);
`default_nettype wire
